// [hdl/pxo_pkg.sv]
package pxo_pkg;

	localparam int PORTD_W = 8;
	localparam int PORTE_W = 4;
	localparam int PIN_W   = PORTD_W + PORTE_W;

	// Port D bit positions
	localparam int PD_RX   = 0;
	localparam int PD_TX   = 1;
	localparam int PD_EXTERNAL_IRQ_ZERO = 2;
	localparam int PD_EXTERNAL_IRQ_ONE = 3;
	localparam int PD_XCK  = 4;
	localparam int PD_TIMER0_COMPARE_B_OUTPUT = 5;
	localparam int PD_TIMER0_COMPARE_A_OUTPUT = 6;

	// Port E bit positions
	localparam int PE_SDA  = 0;
	localparam int PE_SCL  = 1;
	localparam int PE_CAP3 = 2;
	localparam int PE_MOSI = 3;

	// First pin-change source number on port D bit 0
	localparam int PCINT_BASE = 16;

	// Reset values of the pad-facing flops
	localparam logic RST_PAD_OUT  = 1'b0;
	localparam logic RST_PAD_OE_N = 1'b1;
	localparam logic RST_PULLUP   = 1'b0;
	localparam logic RST_LEVEL    = 1'b0;
	localparam logic RST_TW_LEVEL = 1'b1;

	// Spike filter timing
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SPIKE_NS      = 50;
	localparam int SPIKE_CYC     = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SPIKE_CNT_W   = 3;

	typedef struct packed {
		logic pu_en;
		logic pu_val;
		logic dd_en;
		logic dd_val;
		logic pv_en;
		logic pv_val;
		logic di_en;
		logic di_val;
	} pxo_ovr_t;

	localparam pxo_ovr_t OVR_NONE = '{default: 1'b0};

endpackage

// [hdl/pxo_spike_filter.sv]
`timescale 1ns/1ps
module pxo_spike_filter
	import pxo_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic raw_in,
	output logic      clean_out
);

	localparam logic [SPIKE_CNT_W-1:0] CNT_LAST = SPIKE_CNT_W'(SPIKE_CYC - 1);
	localparam logic [SPIKE_CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [SPIKE_CNT_W-1:0] CNT_ONE  = SPIKE_CNT_W'(1);

	logic [SPIKE_CNT_W-1:0] cnt_q;
	logic [SPIKE_CNT_W-1:0] cnt_d;
	logic                   clean_q;
	logic                   clean_d;
	wire                    differs = raw_in != clean_q;
	wire                    settled = differs && (cnt_q == CNT_LAST);

	// A new level must hold for the full window before it is passed on
	assign cnt_d   = (!differs || settled) ? CNT_ZERO : cnt_q + CNT_ONE;
	assign clean_d = settled ? raw_in : clean_q;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q   <= CNT_ZERO;
			clean_q <= RST_TW_LEVEL;
		end
		else
		begin
			cnt_q   <= cnt_d;
			clean_q <= clean_d;
		end
	end

	assign clean_out = clean_q;

endmodule

// [hdl/pxo_port_de_override.sv]
// What this block does
// - Serial transmitter enabled forces D1 output, drives transmit data, pull-up off.
// - Serial receiver enabled forces D0 input and feeds its level to the receiver.
// - Forced D0 input gets pull-up only when data bit set and pull-ups allowed.
// - SPI1 slave forces E3 input and feeds its level as slave data input.
// - SPI1 master keeps E3 direction from register and drives master data output.
// - With SPI1 forcing E3 input, the data bit still controls its pull-up.
// - Two-wire enable detaches E1 and makes it the bidirectional clock line.
// - Two-wire enable detaches E0 and makes it the bidirectional data line.
// - Two-wire clock and data inputs reject pulses shorter than 50 ns.
// - Two-wire pins only pull low or release; they never drive high.
// - Comparator output enable, with two-wire off, overrides E0 pull-up and direction, drives comparator result.
// - E2 level goes to timer 3 capture, E0 level to timer 4 capture.
// - E3 level feeds timer 3 count source, E1 level feeds timer 4.
// - Each pin feeds pin-change source 16..27; input enabled when unmasked and grouped.
// - D3 input enabled by external interrupt 1 or unmasked source 19 with group 2.
// - D2 input enabled by external interrupt 0 or unmasked source 18 with group 1.
// - Global pull-up disable turns off every pull-up on both ports.
`timescale 1ns/1ps
module pxo_port_de_override
	import pxo_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               rst,
	// Port registers and global controls
	input  wire logic [PORTD_W-1:0] portd_data,
	input  wire logic [PORTD_W-1:0] portd_dir,
	input  wire logic [PORTE_W-1:0] porte_data,
	input  wire logic [PORTE_W-1:0] porte_dir,
	input  wire logic               global_pullup_disable,
	input  wire logic               sleep_input_gate,
	// Pads
	input  wire logic [PORTD_W-1:0] portd_pad_in,
	output logic      [PORTD_W-1:0] portd_pad_out,
	output logic      [PORTD_W-1:0] portd_pad_oe_n,
	output logic      [PORTD_W-1:0] portd_pullup,
	input  wire logic [PORTE_W-1:0] porte_pad_in,
	output logic      [PORTE_W-1:0] porte_pad_out,
	output logic      [PORTE_W-1:0] porte_pad_oe_n,
	output logic      [PORTE_W-1:0] porte_pullup,
	// Sampled pin levels for the input registers
	output logic      [PORTD_W-1:0] portd_pin_level,
	output logic      [PORTE_W-1:0] porte_pin_level,
	// Serial 0
	input  wire logic               serial0_transmitter_enable,
	input  wire logic               serial0_tx_line,
	input  wire logic               serial0_receiver_enable,
	output logic                    serial0_rx_line,
	input  wire logic               serial_synchronous_select,
	input  wire logic               serial0_clock_drive,
	output logic                    serial0_external_clock,
	// Timer compare outputs
	input  wire logic               timer0_compare_a_enable,
	input  wire logic               timer0_compare_a_output,
	input  wire logic               timer0_compare_b_enable,
	input  wire logic               timer0_compare_b_output,
	input  wire logic               timer2_compare_b_enable,
	input  wire logic               timer2_compare_b_output,
	// Timer inputs
	output logic                    timer0_count_input,
	output logic                    timer1_count_input,
	output logic                    timer3_count_input,
	output logic                    timer4_count_input,
	output logic                    timer3_capture_input,
	output logic                    timer4_capture_input,
	// SPI1
	input  wire logic               spi_one_enable,
	input  wire logic               spi_controller_role,
	input  wire logic               spi_one_master_out,
	output logic                    spi_one_data_line,
	output logic                    spi_one_select_line,
	// Two-wire interface 1
	input  wire logic               twowire_enable,
	input  wire logic               twowire_one_clock_pull_low,
	input  wire logic               twowire_one_data_pull_low,
	output logic                    twowire_one_clock_line,
	output logic                    twowire_one_data_line,
	// Analog comparator and analog inputs
	input  wire logic               comparator_output_enable,
	input  wire logic               comparator_result,
	input  wire logic               analog6_digital_input_disable,
	input  wire logic               analog7_digital_input_disable,
	// Interrupt inputs
	input  wire logic               external_irq_zero_enable,
	input  wire logic               external_irq_one_enable,
	input  wire logic [PIN_W-1:0]   pin_change_mask,
	input  wire logic               pin_change_group1_enable,
	input  wire logic               pin_change_group2_enable,
	input  wire logic               pin_change_group3_enable,
	output logic                    external_irq_zero,
	output logic                    external_irq_one,
	output logic      [PIN_W-1:0]   pin_change_level
);

	pxo_ovr_t        ovr [PIN_W];
	wire [PIN_W-1:0] reg_data = {porte_data, portd_data};
	wire [PIN_W-1:0] reg_dir  = {porte_dir, portd_dir};
	wire [PIN_W-1:0] pad_in   = {porte_pad_in, portd_pad_in};
	wire             pu_ok    = !global_pullup_disable;

	// Pin-change enables per source, D on group 2 except D2, E on group 3
	wire [PIN_W-1:0] pc_on;
	assign pc_on[PORTD_W-1:0] = pin_change_mask[PORTD_W-1:0] & {PORTD_W{pin_change_group2_enable}};
	assign pc_on[PIN_W-1:PORTD_W] = pin_change_mask[PIN_W-1:PORTD_W] & {PORTE_W{pin_change_group3_enable}};
	wire pc18_on = pin_change_mask[PD_EXTERNAL_IRQ_ZERO] && pin_change_group1_enable;

	// Role decodes
	wire spi_master = spi_one_enable && spi_controller_role;
	wire spi_slave  = spi_one_enable && !spi_controller_role;
	wire aco_drive  = comparator_output_enable && !twowire_enable;

	// Port D override sources
	assign ovr[PD_RX] = '{
		pu_en: serial0_receiver_enable, pu_val: portd_data[PD_RX] && pu_ok,
		dd_en: serial0_receiver_enable, dd_val: 1'b0,
		pv_en: 1'b0, pv_val: 1'b0,
		di_en: pc_on[PD_RX], di_val: 1'b1};
	assign ovr[PD_TX] = '{
		pu_en: serial0_transmitter_enable, pu_val: 1'b0,
		dd_en: serial0_transmitter_enable, dd_val: 1'b1,
		pv_en: serial0_transmitter_enable, pv_val: serial0_tx_line,
		di_en: pc_on[PD_TX], di_val: 1'b1};
	assign ovr[PD_EXTERNAL_IRQ_ZERO] = '{
		pu_en: 1'b0, pu_val: 1'b0, dd_en: 1'b0, dd_val: 1'b0,
		pv_en: 1'b0, pv_val: 1'b0,
		di_en: external_irq_zero_enable || pc18_on, di_val: 1'b1};
	// Compare outputs replace only the value; direction stays with software
	assign ovr[PD_EXTERNAL_IRQ_ONE] = '{
		pu_en: 1'b0, pu_val: 1'b0, dd_en: 1'b0, dd_val: 1'b0,
		pv_en: timer2_compare_b_enable, pv_val: timer2_compare_b_output,
		di_en: external_irq_one_enable || pc_on[PD_EXTERNAL_IRQ_ONE], di_val: 1'b1};
	assign ovr[PD_XCK] = '{
		pu_en: 1'b0, pu_val: 1'b0, dd_en: 1'b0, dd_val: 1'b0,
		pv_en: serial_synchronous_select, pv_val: serial0_clock_drive,
		di_en: pc_on[PD_XCK], di_val: 1'b1};
	assign ovr[PD_TIMER0_COMPARE_B_OUTPUT] = '{
		pu_en: 1'b0, pu_val: 1'b0, dd_en: 1'b0, dd_val: 1'b0,
		pv_en: timer0_compare_b_enable, pv_val: timer0_compare_b_output,
		di_en: pc_on[PD_TIMER0_COMPARE_B_OUTPUT], di_val: 1'b1};
	assign ovr[PD_TIMER0_COMPARE_A_OUTPUT] = '{
		pu_en: 1'b0, pu_val: 1'b0, dd_en: 1'b0, dd_val: 1'b0,
		pv_en: timer0_compare_a_enable, pv_val: timer0_compare_a_output,
		di_en: pc_on[PD_TIMER0_COMPARE_A_OUTPUT], di_val: 1'b1};
	assign ovr[7] = '{
		pu_en: 1'b0, pu_val: 1'b0, dd_en: 1'b0, dd_val: 1'b0,
		pv_en: 1'b0, pv_val: 1'b0,
		di_en: pc_on[7], di_val: 1'b1};

	// Port E override sources
	assign ovr[PORTD_W+PE_MOSI] = '{
		pu_en: spi_master, pu_val: porte_data[PE_MOSI] && pu_ok,
		dd_en: spi_slave, dd_val: 1'b0,
		pv_en: spi_master, pv_val: spi_one_master_out,
		di_en: pc_on[PORTD_W+PE_MOSI] || analog7_digital_input_disable,
		di_val: pc_on[PORTD_W+PE_MOSI]};
	assign ovr[PORTD_W+PE_CAP3] = '{
		pu_en: 1'b0, pu_val: 1'b0, dd_en: spi_slave, dd_val: 1'b0,
		pv_en: 1'b0, pv_val: 1'b0,
		di_en: pc_on[PORTD_W+PE_CAP3] || analog6_digital_input_disable,
		di_val: pc_on[PORTD_W+PE_CAP3]};
	// Open drain: enable the driver only to pull low, value always zero
	assign ovr[PORTD_W+PE_SCL] = '{
		pu_en: twowire_enable, pu_val: porte_data[PE_SCL] && pu_ok,
		dd_en: twowire_enable, dd_val: twowire_one_clock_pull_low,
		pv_en: twowire_enable, pv_val: 1'b0,
		di_en: pc_on[PORTD_W+PE_SCL], di_val: pc_on[PORTD_W+PE_SCL]};
	assign ovr[PORTD_W+PE_SDA] = '{
		pu_en: twowire_enable || aco_drive,
		pu_val: twowire_enable ? (porte_data[PE_SDA] && pu_ok) : 1'b0,
		dd_en: twowire_enable || aco_drive,
		dd_val: twowire_enable ? twowire_one_data_pull_low : 1'b1,
		pv_en: twowire_enable || aco_drive,
		pv_val: twowire_enable ? 1'b0 : comparator_result,
		di_en: pc_on[PORTD_W+PE_SDA], di_val: pc_on[PORTD_W+PE_SDA]};

	// Per-pin resolution and pad flops
	logic [PIN_W-1:0] pad_out_q;
	logic [PIN_W-1:0] pad_oe_n_q;
	logic [PIN_W-1:0] pullup_q;
	logic [PIN_W-1:0] level_q;
	logic [PIN_W-1:0] pad_out_d;
	logic [PIN_W-1:0] pad_oe_n_d;
	logic [PIN_W-1:0] pullup_d;
	logic [PIN_W-1:0] level_d;

	genvar i;
	generate
		for (i = 0; i < PIN_W; i++)
		begin : g_pin
			wire dir_eff = ovr[i].dd_en ? ovr[i].dd_val : reg_dir[i];
			wire val_eff = ovr[i].pv_en ? ovr[i].pv_val : reg_data[i];
			wire pu_norm = !dir_eff && reg_data[i];
			wire pu_eff  = ovr[i].pu_en ? ovr[i].pu_val : pu_norm;
			wire die_eff = ovr[i].di_en ? ovr[i].di_val : !sleep_input_gate;
			assign pad_out_d[i]  = val_eff;
			assign pad_oe_n_d[i] = !dir_eff;
			// Global disable applied last so no override can re-enable a pull-up
			assign pullup_d[i]   = pu_eff && pu_ok;
			assign level_d[i]    = pad_in[i] && die_eff;
		end
	endgenerate

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pad_out_q  <= {PIN_W{RST_PAD_OUT}};
			pad_oe_n_q <= {PIN_W{RST_PAD_OE_N}};
			pullup_q   <= {PIN_W{RST_PULLUP}};
			level_q    <= {PIN_W{RST_LEVEL}};
		end
		else
		begin
			pad_out_q  <= pad_out_d;
			pad_oe_n_q <= pad_oe_n_d;
			pullup_q   <= pullup_d;
			level_q    <= level_d;
		end
	end

	assign portd_pad_out   = pad_out_q[PORTD_W-1:0];
	assign portd_pad_oe_n  = pad_oe_n_q[PORTD_W-1:0];
	assign portd_pullup    = pullup_q[PORTD_W-1:0];
	assign porte_pad_out   = pad_out_q[PIN_W-1:PORTD_W];
	assign porte_pad_oe_n  = pad_oe_n_q[PIN_W-1:PORTD_W];
	assign porte_pullup    = pullup_q[PIN_W-1:PORTD_W];
	assign portd_pin_level = level_q[PORTD_W-1:0];
	assign porte_pin_level = level_q[PIN_W-1:PORTD_W];

	// Two-wire inputs idle high when the interface is off
	wire tw_scl_raw = twowire_enable ? porte_pad_in[PE_SCL] : RST_TW_LEVEL;
	wire tw_sda_raw = twowire_enable ? porte_pad_in[PE_SDA] : RST_TW_LEVEL;

	pxo_spike_filter u_scl_filter
	(
		.ref_clk   (ref_clk),
		.rst       (rst),
		.raw_in    (tw_scl_raw),
		.clean_out (twowire_one_clock_line)
	);

	pxo_spike_filter u_sda_filter
	(
		.ref_clk   (ref_clk),
		.rst       (rst),
		.raw_in    (tw_sda_raw),
		.clean_out (twowire_one_data_line)
	);

	// Peripheral inputs taken from the sampled levels
	assign serial0_rx_line        = level_q[PD_RX];
	assign serial0_external_clock = level_q[PD_XCK];
	assign timer0_count_input     = level_q[PD_XCK];
	assign timer1_count_input     = level_q[PD_TIMER0_COMPARE_B_OUTPUT];
	assign external_irq_zero      = level_q[PD_EXTERNAL_IRQ_ZERO];
	assign external_irq_one       = level_q[PD_EXTERNAL_IRQ_ONE];
	assign timer3_capture_input   = level_q[PORTD_W+PE_CAP3];
	assign timer4_capture_input   = level_q[PORTD_W+PE_SDA];
	assign timer3_count_input     = level_q[PORTD_W+PE_MOSI];
	assign timer4_count_input     = level_q[PORTD_W+PE_SCL];
	assign spi_one_data_line      = level_q[PORTD_W+PE_MOSI];
	assign spi_one_select_line    = level_q[PORTD_W+PE_CAP3];
	assign pin_change_level       = level_q;

endmodule

// [tb/pxo_pad_board.sv]
`timescale 1ns/1ps
module pxo_pad_board
	import pxo_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic [PIN_W-1:0] drive,
	input  wire logic [PIN_W-1:0] oe_n,
	input  wire logic [PIN_W-1:0] pu_on,
	input  wire logic [PIN_W-1:0] ext_en,
	input  wire logic [PIN_W-1:0] ext_val,
	output logic      [PIN_W-1:0] pad_in
);
	// Undriven pads without pull-up flip every cycle so a stale level never passes for a real one
	logic [PIN_W-1:0] float_q = 12'h05a3;
	always @(posedge ref_clk)
		float_q <= ~float_q;
	// Wired-AND: any low driver wins, as on the open-drain lines
	assign pad_in = ((~oe_n | ext_en) & (oe_n | drive) & (~ext_en | ext_val)) | (oe_n & ~ext_en & (pu_on | float_q));
endmodule

// [tb/pxo_port_de_override_asserts.sv]
`timescale 1ns/1ps
module pxo_port_de_override_asserts
	import pxo_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic [PORTD_W-1:0] portd_data,
	input  wire logic [PORTD_W-1:0] portd_pad_out,
	input  wire logic [PORTD_W-1:0] portd_pad_oe_n,
	input  wire logic [PORTD_W-1:0] portd_pullup,
	input  wire logic [PORTE_W-1:0] porte_data,
	input  wire logic [PORTE_W-1:0] porte_dir,
	input  wire logic [PORTE_W-1:0] porte_pad_in,
	input  wire logic [PORTE_W-1:0] porte_pad_out,
	input  wire logic [PORTE_W-1:0] porte_pad_oe_n,
	input  wire logic [PORTE_W-1:0] porte_pullup,
	input  wire logic               global_pullup_disable,
	input  wire logic               serial0_transmitter_enable,
	input  wire logic               serial0_tx_line,
	input  wire logic               serial0_receiver_enable,
	input  wire logic               spi_one_enable,
	input  wire logic               spi_controller_role,
	input  wire logic               spi_one_master_out,
	input  wire logic               twowire_enable,
	input  wire logic               twowire_one_clock_pull_low,
	input  wire logic               twowire_one_clock_line
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	logic [3:0] on_q;
	logic [2:0] run_q;
	logic       prev_q;
	// Filter state is only trusted once the interface has been on a while
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			on_q   <= 4'h0;
			run_q  <= 3'h0;
			prev_q <= 1'b0;
		end
		else
		begin
			on_q   <= !twowire_enable ? 4'h0 : (on_q == 4'hf ? on_q : on_q + 4'h1);
			run_q  <= (porte_pad_in[PE_SCL] != prev_q) ? 3'h0 : (run_q == 3'h7 ? run_q : run_q + 3'h1);
			prev_q <= porte_pad_in[PE_SCL];
		end
	end
	a_tx_forced_out: assert property (serial0_transmitter_enable |=> !portd_pad_oe_n[PD_TX]
		&& portd_pad_out[PD_TX] == $past(serial0_tx_line) && !portd_pullup[PD_TX]) else $error("tx pin not driven");
	a_rx_forced_in: assert property (serial0_receiver_enable |=> portd_pad_oe_n[PD_RX]
		&& portd_pullup[PD_RX] == ($past(portd_data[PD_RX]) && !$past(global_pullup_disable))) else $error("rx pin bad");
	a_pullup_all_off: assert property (global_pullup_disable |=> portd_pullup == '0 && porte_pullup == '0)
		else $error("pull-up on while disabled");
	a_spi_slave_in: assert property (spi_one_enable && !spi_controller_role |=> porte_pad_oe_n[PE_MOSI]
		&& porte_pullup[PE_MOSI] == ($past(porte_data[PE_MOSI]) && !$past(global_pullup_disable)))
		else $error("spi slave pin bad");
	a_spi_master_out: assert property (spi_one_enable && spi_controller_role |=> porte_pad_out[PE_MOSI]
		== $past(spi_one_master_out) && porte_pad_oe_n[PE_MOSI] == !$past(porte_dir[PE_MOSI]))
		else $error("spi master pin bad");
	a_tw_open_drain: assert property (twowire_enable |=> !porte_pad_out[PE_SCL]
		&& porte_pad_oe_n[PE_SCL] == !$past(twowire_one_clock_pull_low)) else $error("clock pin not open drain");
	a_tw_pullup_data: assert property (twowire_enable && !global_pullup_disable |=> porte_pullup[PE_SCL]
		== $past(porte_data[PE_SCL])) else $error("clock pin pull-up bad");
	a_scl_spike_drop: assert property ($changed(twowire_one_clock_line) && on_q == 4'hf |->
		$past(run_q) >= 3'h5 && $past(porte_pad_in[PE_SCL]) == twowire_one_clock_line) else $error("spike passed");
endmodule
bind pxo_port_de_override pxo_port_de_override_asserts chk (.*);

// [tb/pxo_port_de_override_bench.sv]
`timescale 1ns/1ps
module pxo_port_de_override_bench
	import pxo_pkg::*;
;
	logic               ref_clk = 1'b0;
	logic               rst = 1'b1;
	logic [63:0]        cfg = '0;
	logic [PIN_W-1:0]   ext_en = '0;
	logic [PIN_W-1:0]   ext_val = '0;
	logic [PIN_W-1:0]   pads_in, x_oe, x_out, x_pu, x_lv, pin_change_mask, pin_change_level;
	logic [PORTD_W-1:0] portd_data, portd_dir, portd_pad_in, portd_pad_out, portd_pad_oe_n, portd_pullup;
	logic [PORTE_W-1:0] porte_data, porte_dir, porte_pad_in, porte_pad_out, porte_pad_oe_n, porte_pullup;
	logic [PORTD_W-1:0] portd_pin_level;
	logic [PORTE_W-1:0] porte_pin_level;
	logic               global_pullup_disable, sleep_input_gate, serial0_transmitter_enable, serial0_tx_line,
		serial0_receiver_enable, serial_synchronous_select, serial0_clock_drive, timer0_compare_a_enable,
		timer0_compare_a_output, timer0_compare_b_enable, timer0_compare_b_output, timer2_compare_b_enable,
		timer2_compare_b_output, spi_one_enable, spi_controller_role, spi_one_master_out, comparator_output_enable,
		comparator_result, analog6_digital_input_disable, analog7_digital_input_disable, external_irq_zero_enable,
		external_irq_one_enable, pin_change_group1_enable, pin_change_group2_enable, pin_change_group3_enable,
		twowire_one_clock_pull_low, twowire_one_data_pull_low, twowire_enable, serial0_rx_line,
		serial0_external_clock, timer0_count_input, timer1_count_input, timer3_count_input, timer4_count_input,
		timer3_capture_input, timer4_capture_input, spi_one_data_line, spi_one_select_line,
		twowire_one_clock_line, twowire_one_data_line, external_irq_zero, external_irq_one;
	int                 n_fail = 0;
	int                 cmp_count = 0;
	int                 w;
	assign {portd_data, portd_dir, porte_data, porte_dir, pin_change_mask, global_pullup_disable, sleep_input_gate,
		serial0_transmitter_enable, serial0_tx_line, serial0_receiver_enable, serial_synchronous_select,
		serial0_clock_drive, timer0_compare_a_enable, timer0_compare_a_output, timer0_compare_b_enable,
		timer0_compare_b_output, timer2_compare_b_enable, timer2_compare_b_output, spi_one_enable, spi_controller_role,
		spi_one_master_out, comparator_output_enable, comparator_result, analog6_digital_input_disable,
		analog7_digital_input_disable, external_irq_zero_enable, external_irq_one_enable, pin_change_group1_enable,
		pin_change_group2_enable, pin_change_group3_enable, twowire_one_clock_pull_low, twowire_one_data_pull_low,
		twowire_enable} = cfg;
	assign {porte_pad_in, portd_pad_in} = pads_in;
	always #4 ref_clk = ~ref_clk;
	pxo_port_de_override dut (.*);
	pxo_pad_board board (.ref_clk(ref_clk), .drive({porte_pad_out, portd_pad_out}), .oe_n({porte_pad_oe_n,
		portd_pad_oe_n}), .pu_on({porte_pullup, portd_pullup}), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pads_in));
	task automatic check(input string name, input logic [PIN_W-1:0] seen, input logic [PIN_W-1:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Every pad released and quiet while reset is held
	task automatic check_reset();
		check("reset_oe_n", {porte_pad_oe_n, portd_pad_oe_n}, {PIN_W{RST_PAD_OE_N}});
		check("reset_out", {porte_pad_out, portd_pad_out}, {PIN_W{RST_PAD_OUT}});
		check("reset_pullup", {porte_pullup, portd_pullup}, {PIN_W{RST_PULLUP}});
		check("reset_level", pin_change_level, {PIN_W{RST_LEVEL}});
		check("reset_tw", PIN_W'({twowire_one_clock_line, twowire_one_data_line}), PIN_W'({2{RST_TW_LEVEL}}));
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic void calc();
		logic [PIN_W-1:0] dat, dir, val, pu, ien;
		dat = {porte_data, portd_data};
		dir = {porte_dir, portd_dir};
		val = dat;
		if (serial0_receiver_enable) dir[0] = 1'b0;
		if (serial0_transmitter_enable) {dir[1], val[1]} = {1'b1, serial0_tx_line};
		if (timer2_compare_b_enable) val[3] = timer2_compare_b_output;
		if (serial_synchronous_select) val[4] = serial0_clock_drive;
		if (timer0_compare_b_enable) val[5] = timer0_compare_b_output;
		if (timer0_compare_a_enable) val[6] = timer0_compare_a_output;
		if (spi_one_enable && !spi_controller_role) dir[11:10] = 2'b00;
		if (spi_one_enable && spi_controller_role) val[11] = spi_one_master_out;
		if (comparator_output_enable) {dir[8], val[8]} = {1'b1, comparator_result};
		pu = ~dir & dat;
		if (spi_one_enable && spi_controller_role) pu[11] = dat[11];
		if (twowire_enable) {dir[9:8], val[9:8], pu[9:8]} = {twowire_one_clock_pull_low, twowire_one_data_pull_low,
			2'b00, dat[9:8]};
		x_oe = ~dir;
		x_out = val;
		x_pu = global_pullup_disable ? '0 : pu;
		ien = pin_change_mask & {{PORTE_W{pin_change_group3_enable}}, {PORTD_W{pin_change_group2_enable}}};
		ien[2] = external_irq_zero_enable | (pin_change_mask[2] & pin_change_group1_enable);
		ien[3] = ien[3] | external_irq_one_enable;
		x_lv = pads_in & (ien | {PIN_W{!sleep_input_gate}})
			& ~({analog7_digital_input_disable, analog6_digital_input_disable, 10'h000} & ~ien);
	endfunction
	initial
	begin
		void'($urandom(89));
		@(posedge ref_clk);
		@(negedge ref_clk);
		check_reset();
		@(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		calc();
		for (int i = 0; i < 1000; i++)
		begin
			@(posedge ref_clk);
			// Whole configuration set here: alternately all zeros and all ones for four passes, then random
			cfg <= (i < 4) ? {64{i[0]}} : {$urandom, $urandom};
			@(negedge ref_clk);
			check("pad_oe_n", {porte_pad_oe_n, portd_pad_oe_n}, x_oe);
			check("pad_out", {porte_pad_out, portd_pad_out}, x_out);
			check("pullup", {porte_pullup, portd_pullup}, x_pu);
			check("pin_level", {porte_pin_level, portd_pin_level}, x_lv);
			check("pin_change_level", pin_change_level, x_lv);
			check("routes", PIN_W'({serial0_rx_line, external_irq_zero, external_irq_one, timer3_capture_input,
				timer4_capture_input, timer3_count_input, timer4_count_input, spi_one_data_line}),
				PIN_W'({x_lv[0], x_lv[2], x_lv[3], x_lv[10], x_lv[8], x_lv[11], x_lv[9], x_lv[11]}));
			check("routes_d", PIN_W'({serial0_external_clock, timer0_count_input, timer1_count_input,
				spi_one_select_line}), PIN_W'({x_lv[4], x_lv[4], x_lv[5], x_lv[10]}));
			calc();
		end
		// Mid-run reset with idle inputs so no property sees a stale request
		@(posedge ref_clk);
		rst <= 1'b1;
		cfg <= '0;
		@(negedge ref_clk);
		check_reset();
		@(posedge ref_clk);
		rst <= 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			@(posedge ref_clk);
			cfg <= 64'h0000_0000_0000_0001;
			ext_en <= 12'h0300;
			ext_val <= 12'h0300;
			repeat (12) @(posedge ref_clk);
			ext_val[9 - k] <= 1'b0;
			repeat (6) @(posedge ref_clk);
			ext_val[9 - k] <= 1'b1;
			repeat (12)
			begin
				@(negedge ref_clk);
				check("short_pulse", PIN_W'(k ? twowire_one_data_line : twowire_one_clock_line), 12'h0001);
			end
			ext_val[9 - k] <= 1'b0;
			w = 0;
			while ((k ? twowire_one_data_line : twowire_one_clock_line) !== 1'b0 && w < 10)
			begin
				@(negedge ref_clk);
				w++;
			end
			check("long_pulse", PIN_W'(k ? twowire_one_data_line : twowire_one_clock_line), 12'h0000);
			// A level held the full window appears exactly at its last edge
			check("filter_delay", PIN_W'(w), PIN_W'(SPIKE_CYC));
		end
		report_and_stop();
	end
	initial
	begin
		#100000;
		n_fail++;
		report_and_stop();
	end
endmodule
